// ---- ducr_config_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module ducr_config_regs (
   // system
   input wire logic clk,
   input wire logic nrst,
   // serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo_out,
   output logic sdo_oe,
   // status inputs
   input wire logic checksum_error,
   input wire logic ref_alarm_in,
   // register contents
   output ducr_pkg::ducr_mode_s update_mode,
   output ducr_pkg::ducr_setup_s device_setup,
   output logic reference_shutdown,
   output logic [7:0] channel_power_down,
   output logic crc_check_enable,
   // channel updates
   output ducr_pkg::ducr_wr_s data_wr,
   output logic [7:0] channel_update,
   output logic [7:0] bcast_load,
   output logic [15:0] broadcast_value_reg
);
   import ducr_pkg::*;

   // ---------------------------------------------------------------
   // link side state, falling-edge capture
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [4:0] cnt;
      logic [22:0] sh_in;
      logic [23:0] sh_out;
   } ducr_bit_s;

   typedef struct packed {
      ducr_frame_s frame;
      logic tgl;
      logic fast1;
      logic fast2;
   } ducr_link_s;

   ducr_bit_s bit_r, bit_nxt;
   ducr_link_s lnk_r, lnk_nxt;
   logic sdo_pos_r;
   logic frame_rst_n;

   // ---------------------------------------------------------------
   // core side state
   // ---------------------------------------------------------------
   typedef struct packed {
      ducr_mode_s um;
      ducr_setup_s su;
      logic [15:0] bval;
      logic tg1;
      logic tg2;
      logic tg3;
      logic cs1;
      logic cs2;
      logic ra1;
      logic ra2;
      logic fv;
      logic [7:0] pend;
      logic [7:0] upd;
      logic [7:0] bld;
      ducr_wr_s wr;
      logic [15:0] rd_hold;
   } ducr_core_s;

   ducr_core_s st_r, st_nxt;

   // counter and shifters restart while chip select is high
   assign frame_rst_n = nrst & ~cs_n;

   always_comb begin
      bit_nxt = bit_r;
      if (bit_r.cnt != LAST_BIT + 5'd1) begin
         bit_nxt.cnt = bit_r.cnt + 5'd1;
      end
      bit_nxt.sh_in = {bit_r.sh_in[21:0], sdi};
      if (bit_r.cnt == 5'd0) begin
         // read word held quasi-static since the previous frame
         bit_nxt.sh_out = {READ_PAD[6:0], st_r.rd_hold, 1'b0};
      end else begin
         bit_nxt.sh_out = {bit_r.sh_out[22:0], 1'b0};
      end
   end

   always_ff @(negedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bit_r <= '0;
      end else begin
         bit_r <= bit_nxt;
      end
   end

   always_comb begin
      lnk_nxt = lnk_r;
      lnk_nxt.fast1 = st_r.su.early_serial_out;
      lnk_nxt.fast2 = lnk_r.fast1;
      if (bit_r.cnt == LAST_BIT) begin
         lnk_nxt.frame = {bit_r.sh_in, sdi};
         lnk_nxt.tgl = ~lnk_r.tgl;
      end
   end

   always_ff @(negedge sclk or negedge nrst) begin
      if (!nrst) begin
         lnk_r <= '0;
      end else begin
         lnk_r <= lnk_nxt;
      end
   end

   // normal timing: retime the falling-edge bit onto the rising edge
   always_ff @(posedge sclk or negedge nrst) begin
      if (!nrst) begin
         sdo_pos_r <= 1'b0;
      end else begin
         sdo_pos_r <= bit_r.sh_out[23];
      end
   end

   // ---------------------------------------------------------------
   // core side: crossing, commit at chip select release
   // ---------------------------------------------------------------
   logic frame_arrived;
   logic commit;
   ducr_frame_s fr;

   always_comb begin
      st_nxt = st_r;
      fr = lnk_r.frame;
      st_nxt.tg1 = lnk_r.tgl;
      st_nxt.tg2 = st_r.tg1;
      st_nxt.tg3 = st_r.tg2;
      st_nxt.cs1 = cs_n;
      st_nxt.cs2 = st_r.cs1;
      st_nxt.ra1 = ref_alarm_in;
      st_nxt.ra2 = st_r.ra1;
      frame_arrived = st_r.tg2 ^ st_r.tg3;
      // frame word stays stable until the next frame's last bit
      commit = st_r.fv & st_r.cs2;
      st_nxt.upd = '0;
      st_nxt.bld = '0;
      st_nxt.wr.stb = 1'b0;
      if (frame_arrived) begin
         st_nxt.fv = 1'b1;
      end
      if (commit) begin
         st_nxt.fv = frame_arrived;
         if (fr.rd) begin
            unique case (fr.addr)
               ADDR_UPDATE_MODE: st_nxt.rd_hold = st_r.um;
               ADDR_DEVICE_SETUP: st_nxt.rd_hold = st_r.su & SETUP_WRITE_MASK;
               ADDR_BCAST_VALUE: st_nxt.rd_hold = st_r.bval;
               default: st_nxt.rd_hold = '0;
            endcase
         end else begin
            if (fr.addr == ADDR_UPDATE_MODE) begin
               st_nxt.um = fr.data;
            end
            if (fr.addr == ADDR_DEVICE_SETUP) begin
               st_nxt.su = fr.data & SETUP_WRITE_MASK;
            end
            if (fr.addr == ADDR_BCAST_VALUE) begin
               st_nxt.bval = fr.data;
               st_nxt.bld = st_r.um.channel_broadcast_enable;
               st_nxt.upd = st_r.um.channel_broadcast_enable;
            end
            if (fr.addr[CHAN_ADDR_BIT]) begin
               st_nxt.wr = '{stb: 1'b1, addr: fr.addr, data: fr.data};
               if (st_r.um.channel_sync_update_enable[fr.addr[2:0]]) begin
                  st_nxt.pend[fr.addr[2:0]] = 1'b1;
               end else begin
                  st_nxt.upd[fr.addr[2:0]] = 1'b1;
               end
            end
            if (fr.addr == ADDR_TRIGGER && fr.data[TRIG_LOAD_BIT]) begin
               st_nxt.upd = st_nxt.upd | (st_r.pend & st_r.um.channel_sync_update_enable);
               st_nxt.pend = '0;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // chip select syncs start at the idle level so the pin stays off in reset
         st_r <= '{um: UPDATE_MODE_RST, su: DEVICE_SETUP_RST, bval: BCAST_VALUE_RST, cs1: 1'b1, cs2: 1'b1,
                   default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // shared pin and outputs
   // ---------------------------------------------------------------
   logic alarm_cond;

   // alarm source mux
   assign alarm_cond = st_r.su.alarm_source_select ? st_r.ra2 : checksum_error;

   always_comb begin
      if (st_r.su.alarm_pin_enable) begin
         sdo_out = 1'b0;
         sdo_oe = alarm_cond;
      end else begin
         sdo_out = lnk_r.fast2 ? bit_r.sh_out[23] : sdo_pos_r;
         sdo_oe = ~st_r.su.serial_out_disable & ~st_r.cs2;
      end
   end

   assign update_mode = st_r.um;
   assign device_setup = st_r.su;
   assign reference_shutdown = st_r.su.reference_shutdown;
   assign channel_power_down = st_r.su.channel_power_down;
   assign crc_check_enable = st_r.su.crc_enable;
   assign data_wr = st_r.wr;
   assign channel_update = st_r.upd;
   assign bcast_load = st_r.bld;
   assign broadcast_value_reg = st_r.bval;

endmodule // ducr_config_regs
`default_nettype wire

// ---- ducr_pkg.sv ----
// Functional notes
// - channels with broadcast enable set update their output after a broadcast write
// - channels with broadcast enable clear ignore a broadcast write
// - sync enable set: a channel write updates the output only on the load trigger
// - sync enable clear: channel output updates at chip select rise ending the write
// - update-mode register at address 2, resets to ff00
// - setup bits 15:14 reserved, held at zero, writes ignored
// - setup bit 13 picks alarm source: checksum error or reference alarm
// - setup bit 12 set: shared pin is active-low open-drain alarm, sdo bits ignored
// - setup bit 12 clear: shared pin is push-pull serial data out
// - setup bit 11 enables checksum checking of serial frames
// - setup bit 10 clear: sdo changes on sclk rise; set: on sclk fall
// - setup bit 9 set: sdo always off; clear: driven while chip select low
// - setup bit 8 set shuts down the internal reference
// - setup bits 7:0 put their channel into power-down with output grounded
// - writing load bit 4 of the trigger register loads all synchronous channels with a pending write
// - broadcast write loads its value into every broadcast-enabled channel
`default_nettype none
package ducr_pkg;

   // ---------------------------------------------------------------
   // register addresses
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_UPDATE_MODE = 4'h2;
   localparam logic [3:0] ADDR_DEVICE_SETUP = 4'h3;
   localparam logic [3:0] ADDR_TRIGGER = 4'h5;
   localparam logic [3:0] ADDR_BCAST_VALUE = 4'h6;
   localparam int CHAN_ADDR_BIT = 3;

   // ---------------------------------------------------------------
   // reset values and field positions
   // ---------------------------------------------------------------
   localparam logic [15:0] UPDATE_MODE_RST = 16'hff00;
   localparam logic [15:0] DEVICE_SETUP_RST = 16'h0000;
   localparam logic [15:0] BCAST_VALUE_RST = 16'h0000;
   localparam logic [15:0] SETUP_WRITE_MASK = 16'h3fff;
   localparam int TRIG_LOAD_BIT = 4;

   // ---------------------------------------------------------------
   // serial frame
   // ---------------------------------------------------------------
   localparam int FRAME_BITS = 24;
   localparam logic [4:0] LAST_BIT = 5'd23;
   localparam logic [7:0] READ_PAD = 8'h00;

   typedef struct packed {
      logic [7:0] channel_broadcast_enable;
      logic [7:0] channel_sync_update_enable;
   } ducr_mode_s;

   typedef struct packed {
      logic [1:0] reserved;
      logic alarm_source_select;
      logic alarm_pin_enable;
      logic crc_enable;
      logic early_serial_out;
      logic serial_out_disable;
      logic reference_shutdown;
      logic [7:0] channel_power_down;
   } ducr_setup_s;

   typedef struct packed {
      logic rd;
      logic [2:0] spare;
      logic [3:0] addr;
      logic [15:0] data;
   } ducr_frame_s;

   typedef struct packed {
      logic stb;
      logic [3:0] addr;
      logic [15:0] data;
   } ducr_wr_s;

endpackage
`default_nettype wire

// ---- ducr_config_regs_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module ducr_config_regs_chk (
   // watched ports
   input wire logic clk,
   input wire logic nrst,
   input wire logic cs_n,
   input wire logic sdo_oe,
   input wire ducr_pkg::ducr_mode_s update_mode,
   input wire ducr_pkg::ducr_setup_s device_setup,
   input wire logic reference_shutdown,
   input wire logic [7:0] channel_power_down,
   input wire logic crc_check_enable,
   input wire ducr_pkg::ducr_wr_s data_wr,
   input wire logic [7:0] channel_update,
   input wire logic [7:0] bcast_load
);
   import ducr_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_rsv; device_setup[15:14] == 2'b00; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved set");
   property p_pd; channel_power_down == device_setup[7:0]; endproperty
   a_pd: assert property (p_pd) else $error("power-down");
   property p_ref; reference_shutdown == device_setup[8]; endproperty
   a_ref: assert property (p_ref) else $error("ref");
   property p_crc; crc_check_enable == device_setup[11]; endproperty
   a_crc: assert property (p_crc) else $error("crc");
   property p_ben; (bcast_load & ~update_mode[15:8]) == 8'h00; endproperty
   a_ben: assert property (p_ben) else $error("bcast mask");
   property p_bup; bcast_load != 8'h00 |-> channel_update == bcast_load; endproperty
   a_bup: assert property (p_bup) else $error("bcast update");
   property p_async;
      data_wr.stb && data_wr.addr[3] |-> channel_update[data_wr.addr[2:0]] == !update_mode[data_wr.addr[2:0]];
   endproperty
   a_async: assert property (p_async) else $error("async update");
   property p_sync;
      !data_wr.stb && bcast_load == 8'h00 |-> (channel_update & ~update_mode[7:0]) == 8'h00;
   endproperty
   a_sync: assert property (p_sync) else $error("sync update");
   property p_dis; device_setup[9] && !device_setup[12] |-> !sdo_oe; endproperty
   a_dis: assert property (p_dis) else $error("sdo disable");
   property p_idle; cs_n [*4] ##0 !device_setup[12] |-> !sdo_oe; endproperty
   a_idle: assert property (p_idle) else $error("sdo idle");
endmodule // ducr_config_regs_chk
bind ducr_config_regs ducr_config_regs_chk ducr_config_regs_chk_inst (.clk(clk), .nrst(nrst), .cs_n(cs_n),
   .sdo_oe(sdo_oe), .update_mode(update_mode), .device_setup(device_setup),
   .reference_shutdown(reference_shutdown), .channel_power_down(channel_power_down),
   .crc_check_enable(crc_check_enable), .data_wr(data_wr), .channel_update(channel_update),
   .bcast_load(bcast_load));
`default_nettype wire

// ---- ducr_spi_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module ducr_spi_host (
   // link
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo_line
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   // one 24-bit frame, sdo taken just before each fall
   task automatic xfer(input logic [23:0] f, output logic [15:0] r);
      cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdi = f[i];
         #8 sclk = 1'b1;
         #15 r = {r[14:0], sdo_line};
         #1 sclk = 1'b0;
         #8;
      end
      cs_n = 1'b1;
      sdi = ~sdi; // released line must not hold last bit
      #400;
   endtask
endmodule // ducr_spi_host
`default_nettype wire

// ---- test_ducr_config_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_ducr_config_regs;
   import ducr_pkg::*;
   logic clk, nrst, checksum_error, ref_alarm_in, sclk, cs_n, sdi, sdo_out, sdo_oe, sdo_line;
   logic reference_shutdown, crc_check_enable;
   logic [7:0] channel_power_down, channel_update, bcast_load, upd_acc, bl_acc;
   logic [15:0] broadcast_value_reg, rv;
   ducr_mode_s update_mode;
   ducr_setup_s device_setup;
   ducr_wr_s data_wr, wr_seen;
   int num_errors = 0;
   int checks_done = 0;
   assign sdo_line = sdo_oe ? sdo_out : 1'b1; // pull-up on shared pin
   ducr_config_regs ducr_config_regs_inst (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
      .sdo_out(sdo_out), .sdo_oe(sdo_oe), .checksum_error(checksum_error), .ref_alarm_in(ref_alarm_in),
      .update_mode(update_mode), .device_setup(device_setup), .reference_shutdown(reference_shutdown),
      .channel_power_down(channel_power_down), .crc_check_enable(crc_check_enable), .data_wr(data_wr),
      .channel_update(channel_update), .bcast_load(bcast_load), .broadcast_value_reg(broadcast_value_reg));
   ducr_spi_host ducr_spi_host_inst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_line(sdo_line));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      upd_acc <= upd_acc | channel_update;
      bl_acc <= bl_acc | bcast_load;
      if (data_wr.stb) begin
         wr_seen <= data_wr;
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      logic [15:0] r;
      ducr_spi_host_inst.xfer({4'h0, a, d}, r);
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      ducr_spi_host_inst.xfer({4'h8, a, 16'h0000}, d);
      ducr_spi_host_inst.xfer(24'h000000, d);
   endtask
   task automatic clr();
      @(negedge clk);
      upd_acc = 8'h00;
      bl_acc = 8'h00;
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #500000;
      num_errors++;
      stop_test();
   end
   initial begin
      nrst = 1'b0;
      checksum_error = 1'b0;
      ref_alarm_in = 1'b0;
      upd_acc = 8'h00;
      bl_acc = 8'h00;
      repeat (8) @(posedge clk);
      check("oe rst", {15'h0000, sdo_oe}, 16'h0000);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      check("mode", update_mode, 16'hff00);
      check("setup", device_setup, 16'h0000);
      rd(ADDR_UPDATE_MODE, rv);
      check("rd mode", rv, 16'hff00);
      $display("test reset done");
      wr(ADDR_DEVICE_SETUP, 16'hffff);
      check("setup", device_setup, 16'h3fff);
      check("ref", {15'h0000, reference_shutdown}, 16'h0001);
      check("pd", {8'h00, channel_power_down}, 16'h00ff);
      check("crc", {15'h0000, crc_check_enable}, 16'h0001);
      wr(ADDR_DEVICE_SETUP, 16'hc5a5);
      rd(ADDR_DEVICE_SETUP, rv);
      check("rd fast", rv, 16'h05a5);
      $display("test setup done");
      wr(ADDR_UPDATE_MODE, 16'h5a00);
      clr();
      wr(ADDR_BCAST_VALUE, 16'h1234);
      check("bload", {8'h00, bl_acc}, 16'h005a);
      check("bupd", {8'h00, upd_acc}, 16'h005a);
      check("bval", broadcast_value_reg, 16'h1234);
      wr(ADDR_UPDATE_MODE, 16'h0004);
      clr();
      wr(4'ha, 16'h1111);
      check("sync", {8'h00, upd_acc}, 16'h0000);
      wr(4'hb, 16'h2222);
      check("async", {8'h00, upd_acc}, 16'h0008);
      check("wr data", wr_seen.data, 16'h2222);
      check("wr addr", {12'h000, wr_seen.addr}, 16'h000b);
      wr(ADDR_TRIGGER, 16'h0010);
      check("load", {8'h00, upd_acc}, 16'h000c);
      $display("test update done");
      wr(ADDR_DEVICE_SETUP, 16'h0200);
      rd(ADDR_DEVICE_SETUP, rv);
      check("serial_out_disable", rv, 16'hffff);
      wr(ADDR_DEVICE_SETUP, 16'h1000);
      @(posedge clk) checksum_error <= 1'b1;
      repeat (4) @(posedge clk);
      check("alm crc", {14'h0000, sdo_oe, sdo_out}, 16'h0002);
      wr(ADDR_DEVICE_SETUP, 16'h3000);
      check("alarm_source_select", {15'h0000, sdo_oe}, 16'h0000);
      @(posedge clk) ref_alarm_in <= 1'b1;
      repeat (4) @(posedge clk);
      check("alm ref", {15'h0000, sdo_oe}, 16'h0001);
      wr(ADDR_DEVICE_SETUP, 16'h0000);
      rd(ADDR_DEVICE_SETUP, rv);
      check("sdo", rv, 16'h0000);
      $display("test pin done");
      stop_test();
   end
endmodule // test_ducr_config_regs
`default_nettype wire
